// *** bench/mpsl_media_model.sv ***
// behavioural model of the media side: link, jumper, jabber, collision
`timescale 1ns/1ps
module mpsl_media_model (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic link_cmd,
    input  wire logic jumper_cmd,
    input  wire logic jabber_cmd,
    input  wire logic col_cmd,
    output logic      tp_link_pin,
    output logic      port_jumper_pin,
    output logic      jabber_event,
    output logic      collision_event
);
    // ========================================================================
    // pin drivers
    // events change just after an edge, as a same-clock source would
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tp_link_pin     <= 1'b0;
            jabber_event    <= 1'b0;
            collision_event <= 1'b0;
        end else begin
            tp_link_pin     <= link_cmd;
            jabber_event    <= jabber_cmd;
            collision_event <= col_cmd;
        end
    end
    // a strap holds its level through reset
    assign port_jumper_pin = jumper_cmd;
endmodule // mpsl_media_model

// *** bench/mpsl_top_tb.sv ***
// self-checking testbench for the media port select and FIRST_INDICATOR_PIN block
`timescale 1ns/1ps
module mpsl_top_tb;
    import mpsl_pkg::*;
    logic        sys_clk;
    logic        rst_b;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tp_link_pin;
    logic        port_jumper_pin;
    logic        jabber_event;
    logic        collision_event;
    logic        sleep_mode;
    logic        port_is_tp;
    logic        tp_rx_enable;
    logic        external_address_detect_en;
    logic        first_indicator_pin;
    logic        irq;
    logic        link_cmd;
    logic        jumper_cmd;
    logic        jabber_cmd;
    logic        col_cmd;
    logic [31:0] rd;
    logic        err;
    int          n_errors;
    int          compares;

    mpsl_top DUT (.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tp_link_pin(tp_link_pin), .port_jumper_pin(port_jumper_pin),
        .jabber_event(jabber_event), .collision_event(collision_event),
        .sleep_mode(sleep_mode), .port_is_tp(port_is_tp),
        .tp_rx_enable(tp_rx_enable),
        .external_address_detect_en(external_address_detect_en),
        .first_indicator_pin(first_indicator_pin), .irq(irq));

    mpsl_media_model media (.sys_clk(sys_clk), .rst_b(rst_b),
        .link_cmd(link_cmd), .jumper_cmd(jumper_cmd),
        .jabber_cmd(jabber_cmd), .col_cmd(col_cmd),
        .tp_link_pin(tp_link_pin), .port_jumper_pin(port_jumper_pin),
        .jabber_event(jabber_event), .collision_event(collision_event));

    // ========================================================================
    // clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        final_report();
    end

    // ========================================================================
    // tasks
    task automatic final_report();
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // one APB transfer; waits on pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= 4'hF;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            n_errors++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        cmp_reg(rd, exp);
    endtask

    // pins reach outputs after three edges, config after two
    task automatic settle();
        repeat (5) @(posedge sys_clk);
    endtask

    // ========================================================================
    // main sequence
    initial begin
        rst_b = 1'b0;
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        sleep_mode = 1'b0;
        link_cmd = 1'b0;
        jumper_cmd = 1'b0;
        jabber_cmd = 1'b0;
        col_cmd = 1'b0;
        n_errors = 0;
        compares = 0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd_chk(OFF_CFG, 32'h0000_0001);
        rd_chk(OFF_LEDCTL, 32'h0000_0001);
        rd_chk(OFF_IRQ_MASK, 32'h0000_0000);
        link_cmd <= 1'b1;
        settle();
        cmp_pin(port_is_tp, 1'b1);
        cmp_pin(first_indicator_pin, 1'b1);
        rd_chk(OFF_LEDSTAT, 32'h0000_8000);
        wr_reg(OFF_LEDSTAT, 32'h0000_0000);
        rd_chk(OFF_LEDSTAT, 32'h0000_8000);
        link_cmd <= 1'b0;
        settle();
        cmp_pin(port_is_tp, 1'b0);
        cmp_pin(first_indicator_pin, 1'b0);
        wr_reg(OFF_CFG, 32'h0000_0010);
        settle();
        cmp_pin(port_is_tp, 1'b1);
        wr_reg(OFF_CFG, 32'h0000_0020);
        settle();
        cmp_pin(port_is_tp, 1'b0);
        rd_chk(OFF_CFG, 32'h0000_0020);
        // jumper low must beat auto select with a good link
        link_cmd <= 1'b1;
        wr_reg(OFF_CFG, 32'h0000_0003);
        settle();
        cmp_pin(port_is_tp, 1'b0);
        jumper_cmd <= 1'b1;
        settle();
        cmp_pin(port_is_tp, 1'b1);
        rd_chk(OFF_STATUS, 32'h0000_0025);
        wr_reg(OFF_CFG, 32'h0000_0004);
        settle();
        cmp_pin(external_address_detect_en, 1'b1);
        wr_reg(OFF_CFG, 32'h0000_0006);
        settle();
        cmp_pin(external_address_detect_en, 1'b0);
        // auto-wake while asleep on the twisted pair port
        sleep_mode <= 1'b1;
        wr_reg(OFF_CFG, 32'h0000_0018);
        settle();
        cmp_pin(tp_rx_enable, 1'b1);
        cmp_pin(first_indicator_pin, 1'b1);
        link_cmd <= 1'b0;
        settle();
        cmp_pin(first_indicator_pin, 1'b0);
        link_cmd <= 1'b1;
        settle();
        cmp_pin(first_indicator_pin, 1'b1);
        wr_reg(OFF_LEDCTL, 32'h0000_0000);
        settle();
        cmp_pin(tp_rx_enable, 1'b0);
        wr_reg(OFF_LEDCTL, 32'h0000_0001);
        wr_reg(OFF_CFG, 32'h0000_0010);
        settle();
        cmp_pin(tp_rx_enable, 1'b0);
        wr_reg(OFF_CFG, 32'h0000_0028);
        settle();
        cmp_pin(tp_rx_enable, 1'b0);
        sleep_mode <= 1'b0;
        // jabber routing, interrupt raise and read-clear
        link_cmd <= 1'b0;
        settle();
        apb(1'b0, OFF_IRQ_STAT, 32'h0000_0000);
        wr_reg(OFF_IRQ_MASK, 32'h0000_0004);
        wr_reg(OFF_LEDCTL, 32'h0000_0002);
        jabber_cmd <= 1'b1;
        settle();
        cmp_pin(first_indicator_pin, 1'b1);
        cmp_pin(irq, 1'b1);
        rd_chk(OFF_IRQ_STAT, 32'h0000_0004);
        settle();
        cmp_pin(irq, 1'b0);
        wr_reg(OFF_LEDCTL, 32'h0000_0000);
        settle();
        cmp_pin(first_indicator_pin, 1'b0);
        jabber_cmd <= 1'b0;
        col_cmd <= 1'b1;
        wr_reg(OFF_LEDCTL, 32'h0000_0004);
        settle();
        cmp_pin(first_indicator_pin, 1'b1);
        col_cmd <= 1'b0;
        link_cmd <= 1'b1;
        wr_reg(OFF_LEDCTL, 32'h0000_0005);
        settle();
        cmp_pin(first_indicator_pin, 1'b1);
        apb(1'b0, 8'h20, 32'h0000_0000);
        cmp_pin(err, 1'b1);
        cmp_reg(rd, 32'h0000_0000);
        final_report();
    end
endmodule // mpsl_top_tb

// *** hw/mpsl_pkg.sv ***
// constants, field layouts and types for the media port select and FIRST_INDICATOR_PIN block
//
// Operation
// - ext_addr_match_select enables external address match only while hw_port_select is 0
// - link_state and link_wake_enable keep 10BASE-T receive alive during sleep
// - during auto-wake first_indicator_pin shows link and rises on leaving link fail
// - link_wake_enable 0 disables auto-wake; it matters only with 10BASE-T selected
// - auto_port_select lets the device pick the port; reset sets it
// - hw_port_select set means hardware picks the port; reset clears it
// - with hw_port_select 0 and auto_port_select 0 the port comes from sw_port_choice
// - with hw_port_select 1 the port comes from port_jumper_pin
// - led_zero_status_reg is read only and mirrors first_indicator_pin
// - first_indicator_pin shows twisted pair link status by default
// - jabber_indicate_en 1 routes jabber to the LED, 0 blocks it; during auto-wake the code shows link only
// - several enabled LED functions are ORed onto the pin; during auto-wake the code shows link only
package mpsl_pkg;

    // ========================================================================
    // register map, byte addresses on the APB
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam logic [7:0]  OFF_CFG      = 8'h00;
    localparam logic [7:0]  OFF_LEDCTL   = 8'h04;
    localparam logic [7:0]  OFF_LEDSTAT  = 8'h08;
    localparam logic [7:0]  OFF_STATUS   = 8'h0C;
    localparam logic [7:0]  OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0]  OFF_IRQ_MASK = 8'h14;

    // ========================================================================
    // field layouts
    localparam int          CFG_W        = 6;
    localparam int          LEDCTL_W     = 3;
    localparam int          LEDSTAT_PIN  = 15;
    localparam int          STATUS_W     = 6;
    localparam int          IRQ_W        = 4;
    localparam int          IRQ_LINK_UP  = 0;
    localparam int          IRQ_LINK_DN  = 1;
    localparam int          IRQ_JABBER   = 2;
    localparam int          IRQ_CONFLICT = 3;

    // ========================================================================
    // reset values and encodings
    localparam logic [5:0]  CFG_RESET    = 6'h01;
    localparam logic [2:0]  LEDCTL_RESET = 3'h1;
    localparam logic [3:0]  IRQ_RESET    = 4'h0;
    localparam logic [1:0]  PSEL_AUI     = 2'h0;
    localparam logic [1:0]  PSEL_TP      = 2'h1;

    // ========================================================================
    // types
    typedef enum logic [1:0] {
        MPSL_MODE_SW,
        MPSL_MODE_AUTO,
        MPSL_MODE_JUMPER
    } mpsl_mode_t;

    typedef enum logic {
        MPSL_PORT_AUI,
        MPSL_PORT_TP
    } mpsl_port_t;

    // packed in register bit order, bit 0 last
    typedef struct packed {
        logic [1:0] sw_port_choice;
        logic       link_wake_enable;
        logic       ext_addr_match_select;
        logic       hw_port_select;
        logic       auto_port_select;
    } mpsl_cfg_t;

    typedef struct packed {
        logic       col_indicate_en;
        logic       jabber_indicate_en;
        logic       link_state;
    } mpsl_ledctl_t;

    typedef struct packed {
        logic       port_is_tp;
        logic       tp_rx_enable;
        logic       external_address_detect_en;
        logic       first_indicator_pin;
    } mpsl_out_t;

endpackage

// *** hw/mpsl_port_sel.sv ***
// media port choice: jumper, automatic or software
`timescale 1ns/1ps
module mpsl_port_sel (
    input  wire mpsl_pkg::mpsl_cfg_t  cfg,
    input  wire logic                 jumper_level,
    input  wire logic                 link_good,
    output mpsl_pkg::mpsl_mode_t      mode,
    output mpsl_pkg::mpsl_port_t      port
);
    import mpsl_pkg::*;

    always_comb begin
        if (cfg.hw_port_select) begin
            mode = MPSL_MODE_JUMPER;
            // jumper high picks twisted pair
            port = jumper_level ? MPSL_PORT_TP : MPSL_PORT_AUI;
        end else if (cfg.auto_port_select) begin
            mode = MPSL_MODE_AUTO;
            // twisted pair wins whenever it has link, else fall back to AUI
            port = link_good ? MPSL_PORT_TP : MPSL_PORT_AUI;
        end else begin
            mode = MPSL_MODE_SW;
            // reserved codes fall back to AUI
            port = (cfg.sw_port_choice == PSEL_TP) ? MPSL_PORT_TP
                                                   : MPSL_PORT_AUI;
        end
    end
endmodule // mpsl_port_sel

// *** hw/mpsl_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module mpsl_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    import mpsl_pkg::*;

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    always_comb begin
        next_meta = async_in;
        next_sync = meta;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= next_meta;
            sync_out <= next_sync;
        end
    end
endmodule // mpsl_sync

// *** hw/mpsl_top.sv ***
// media port select, auto-wake and FIRST_INDICATOR_PIN logic with APB registers
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module mpsl_top (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    input  wire logic [mpsl_pkg::ADDR_W-1:0] paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [mpsl_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [mpsl_pkg::DATA_W-1:0] prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     tp_link_pin,
    input  wire logic                     port_jumper_pin,
    input  wire logic                     jabber_event,
    input  wire logic                     collision_event,
    input  wire logic                     sleep_mode,
    output logic                          port_is_tp,
    output logic                          tp_rx_enable,
    output logic                          external_address_detect_en,
    output logic                          first_indicator_pin,
    output logic                          irq
);
    import mpsl_pkg::*;

    // ========================================================================
    // address decode
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFF_CFG) || (a == OFF_LEDCTL) ||
                    (a == OFF_LEDSTAT) || (a == OFF_STATUS) ||
                    (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
    endfunction

    // ========================================================================
    // pin synchronisers
    logic [1:0]   pins_sync;
    logic         link_good;
    logic         jumper_level;

    mpsl_sync #(.W(2)) u_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .async_in ({port_jumper_pin, tp_link_pin}),
        .sync_out (pins_sync)
    );

    assign link_good    = pins_sync[0];
    assign jumper_level = pins_sync[1];

    // ========================================================================
    // registers and bus strobes
    mpsl_cfg_t    cfg;
    mpsl_cfg_t    next_cfg;
    mpsl_ledctl_t ledctl;
    mpsl_ledctl_t next_ledctl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [DATA_W-1:0] next_prdata;
    logic         setup_ph;
    logic         access_ph;
    logic         wr_en;
    logic         rd_irq;

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    // only lane 0 holds writable bits
    assign wr_en     = access_ph && pwrite && pstrb[0];
    assign rd_irq    = access_ph && !pwrite && (paddr == OFF_IRQ_STAT);

    // zero wait state slave; read data captured in the setup cycle
    assign pready    = 1'b1;
    assign pslverr   = access_ph && !is_mapped(paddr);

    // ========================================================================
    // port choice
    mpsl_mode_t   mode;
    mpsl_port_t   sel_port;

    mpsl_port_sel u_port_sel (
        .cfg          (cfg),
        .jumper_level (jumper_level),
        .link_good    (link_good),
        .mode         (mode),
        .port         (sel_port)
    );

    // ========================================================================
    // outputs and event detection
    mpsl_out_t    outs;
    mpsl_out_t    next_outs;
    logic         wake_active;
    logic         led_func;
    logic         link_prev;
    logic         jab_prev;
    logic         conflict_prev;
    logic         next_link_prev;
    logic         next_jab_prev;
    logic         next_conflict_prev;
    logic [IRQ_W-1:0] events;
    logic         conflict;

    // auto-wake only counts with twisted pair selected
    assign wake_active = sleep_mode && ledctl.link_state &&
                         cfg.link_wake_enable &&
                         (sel_port == MPSL_PORT_TP);
    assign conflict    = cfg.ext_addr_match_select && cfg.hw_port_select;

    always_comb begin
        next_outs.port_is_tp = (sel_port == MPSL_PORT_TP);
        // awake the receiver runs on twisted pair; asleep only for wake
        next_outs.tp_rx_enable = (!sleep_mode &&
                                  (sel_port == MPSL_PORT_TP)) ||
                                 wake_active;
        next_outs.external_address_detect_en =
            cfg.ext_addr_match_select && !cfg.hw_port_select;
        if (wake_active) begin
            led_func = link_good;
        end else begin
            led_func = (ledctl.link_state && link_good) ||
                       (ledctl.jabber_indicate_en && jabber_event) ||
                       (ledctl.col_indicate_en && collision_event);
        end
        next_outs.first_indicator_pin = led_func;
        next_link_prev     = link_good;
        next_jab_prev      = jabber_event;
        next_conflict_prev = conflict;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            outs          <= '0;
            link_prev     <= 1'b0;
            jab_prev      <= 1'b0;
            conflict_prev <= 1'b0;
        end else begin
            outs          <= next_outs;
            link_prev     <= next_link_prev;
            jab_prev      <= next_jab_prev;
            conflict_prev <= next_conflict_prev;
        end
    end

    assign port_is_tp                 = outs.port_is_tp;
    assign tp_rx_enable               = outs.tp_rx_enable;
    assign external_address_detect_en = outs.external_address_detect_en;
    assign first_indicator_pin        = outs.first_indicator_pin;

    always_comb begin
        events               = '0;
        events[IRQ_LINK_UP]  = link_good && !link_prev;
        events[IRQ_LINK_DN]  = !link_good && link_prev;
        events[IRQ_JABBER]   = jabber_event && !jab_prev;
        // software broke the external match precondition
        events[IRQ_CONFLICT] = conflict && !conflict_prev;
    end

    // ========================================================================
    // register write, read-clear and read data
    always_comb begin
        next_cfg      = cfg;
        next_ledctl   = ledctl;
        next_irq_mask = irq_mask;
        if (wr_en && paddr == OFF_CFG) begin
            next_cfg = mpsl_cfg_t'(pwdata[CFG_W-1:0]);
        end
        if (wr_en && paddr == OFF_LEDCTL) begin
            next_ledctl = mpsl_ledctl_t'(pwdata[LEDCTL_W-1:0]);
        end
        if (wr_en && paddr == OFF_IRQ_MASK) begin
            next_irq_mask = pwdata[IRQ_W-1:0];
        end
        // writes to the LED status word are dropped on purpose
        // clear only what the read returned; a new event sets regardless
        next_irq_stat = irq_stat;
        if (rd_irq) begin
            next_irq_stat = irq_stat & ~prdata[IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | events;
        next_prdata = '0;
        if (setup_ph && !pwrite) begin
            case (paddr)
                OFF_CFG:      next_prdata[CFG_W-1:0] = cfg;
                OFF_LEDCTL:   next_prdata[LEDCTL_W-1:0] = ledctl;
                OFF_LEDSTAT:  next_prdata[LEDSTAT_PIN] =
                                  outs.first_indicator_pin;
                OFF_STATUS:   next_prdata[STATUS_W-1:0] =
                                  {mode, wake_active, link_good,
                                   outs.external_address_detect_en,
                                   outs.port_is_tp};
                OFF_IRQ_STAT: next_prdata[IRQ_W-1:0] = irq_stat;
                OFF_IRQ_MASK: next_prdata[IRQ_W-1:0] = irq_mask;
                default:      next_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg      <= mpsl_cfg_t'(CFG_RESET);
            ledctl   <= mpsl_ledctl_t'(LEDCTL_RESET);
            irq_stat <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            prdata   <= '0;
            irq      <= 1'b0;
        end else begin
            cfg      <= next_cfg;
            ledctl   <= next_ledctl;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            prdata   <= next_prdata;
            irq      <= |(next_irq_stat & next_irq_mask);
        end
    end

    // ========================================================================
    // checks
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    chk_ext_match_on: assert property (
        cfg.ext_addr_match_select && !cfg.hw_port_select
        |=> external_address_detect_en)
        else $error("external match not enabled");

    chk_ext_match_hw: assert property (
        cfg.hw_port_select |=> !external_address_detect_en)
        else $error("external match enabled with hardware port select");

    chk_wake_rx: assert property (
        sleep_mode && ledctl.link_state && cfg.link_wake_enable &&
        sel_port == MPSL_PORT_TP |=> tp_rx_enable)
        else $error("receiver off during auto-wake");

    chk_wake_led: assert property (
        wake_active && $rose(link_good) |=> first_indicator_pin)
        else $error("LED did not rise on link during auto-wake");

    chk_wake_off: assert property (
        sleep_mode && !cfg.link_wake_enable |=> !tp_rx_enable)
        else $error("receiver on in sleep without auto-wake");

    chk_reset_cfg: assert property (
        $rose(rst_b) |-> cfg.auto_port_select && !cfg.hw_port_select)
        else $error("wrong port select mode after reset");

    chk_jumper_sel: assert property (
        cfg.hw_port_select && jumper_level
        |=> port_is_tp ##0 $past(mode) == MPSL_MODE_JUMPER)
        else $error("jumper choice not followed");

    chk_sw_sel: assert property (
        !cfg.hw_port_select && !cfg.auto_port_select
        |=> port_is_tp == ($past(cfg.sw_port_choice) == PSEL_TP))
        else $error("software port choice not followed");

    chk_auto_sel: assert property (
        !cfg.hw_port_select && cfg.auto_port_select
        |=> port_is_tp == $past(link_good))
        else $error("automatic port choice wrong");

    chk_led_mirror: assert property (
        setup_ph && !pwrite && paddr == OFF_LEDSTAT
        |=> prdata[LEDSTAT_PIN] == $past(first_indicator_pin))
        else $error("LED status bit does not mirror the pin");

    chk_jab_route: assert property (
        !wake_active && ledctl.jabber_indicate_en && jabber_event
        |=> first_indicator_pin)
        else $error("enabled jabber not shown on LED");

    chk_led_idle: assert property (
        !wake_active && !(ledctl.link_state && link_good) &&
        !(ledctl.jabber_indicate_en && jabber_event) &&
        !(ledctl.col_indicate_en && collision_event)
        |=> !first_indicator_pin)
        else $error("LED lit with no enabled function");

    // irq is registered from the next status and mask, so it lines up
    chk_irq_level: assert property (
        irq == |(irq_stat & irq_mask))
        else $error("interrupt level does not follow masked status");

    chk_led_default: assert property (
        $rose(rst_b) |-> ledctl.link_state)
        else $error("LED link display not enabled after reset");

    chk_irq_sticky: assert property (
        irq_stat[IRQ_JABBER] && !rd_irq |=> irq_stat[IRQ_JABBER])
        else $error("jabber status bit lost without a read");

    // an event in the clearing cycle must survive the read
    chk_irq_set_wins: assert property (
        events[IRQ_JABBER] |=> irq_stat[IRQ_JABBER])
        else $error("jabber event not latched");

    cov_auto_wake: cover property (wake_active ##1 first_indicator_pin);
    cov_jumper: cover property (mode == MPSL_MODE_JUMPER ##1 port_is_tp);
    cov_ext_match: cover property ($rose(external_address_detect_en));
    cov_irq_clear: cover property (irq ##1 rd_irq ##1 !irq);

endmodule // mpsl_top
